// [modulo_timer_timer.sv]
// modulo timer: 8-bit prescaled up-counter with apb registers and interrupt
//
// Function
// - overflow flag, status bit 7, sets when count wraps from limit to zero.
// - flag clears by reading status while set, then writing 0 to it.
// - counter clear strobe or any wrap limit write also clears the flag.
// - interrupt enable bit 6 raises irq while flag set; reset clears enable.
// - writing 1 to bit 5 zeroes counter and flag; reads as 0.
// - halt bit 4 freezes count; clearing resumes; reset sets halt.
// - status bits 3:0 and clock config bits 7:6 read as zero.
// - source select 5:4 picks bus, fixed clock, pin falling or rising edge.
// - source change keeps the count and continues with the new source.
// - prescale code 0 to 8 divides by 1 up to 256.
// - prescale codes above 8 divide by 256.
// - prescale change keeps the count and continues at the new ratio.
// - reset clears source select and prescale select to zero.
// - count rises to limit then wraps to zero; limit zero is free-running.
// - current count register is read-only, writes ignored.
// - external clock synchronised; it must stay below a quarter bus rate.
`timescale 1ns/100ps
module modulo_timer_timer
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // clock inputs
    input  wire logic        fixed_frequency_clock,
    input  wire logic        external_timer_clock,
    // interrupt
    output logic             irq
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  ext_sync;
        logic [2:0]  fix_sync;
        logic        ext_lvl;
        logic        fix_lvl;
        logic [7:0]  pre_cnt;
        logic [7:0]  count;
        logic [7:0]  limit;
        logic        ovf_flag;
        logic        ovf_armed;
        logic        ovf_ie;
        logic        halt;
        logic [1:0]  clk_src;
        logic [3:0]  prescale;
        logic        irq_sticky;
        logic        irq_mask;
        logic [31:0] rdata;
        logic        irq_out;
        logic        ack;
    } modulo_timer_state_t;

    modulo_timer_state_t st_r;
    modulo_timer_state_t st_nxt;

    logic        acc;
    logic        wr;
    logic        rd;
    logic        rd_load;
    logic        wr_lane0;
    logic        src_tick;
    logic        pre_tick;
    logic        wrap;
    logic        ext_new;
    logic        fix_new;
    logic [3:0]  ps_eff;
    logic [7:0]  pre_mask;
    logic [7:0]  rd_byte;
    logic        hit;

    // one wait state: the read word is loaded into a flip-flop in the first
    // access cycle, so it already stands on prdata when pready is high;
    // writes and the read side effects happen only at the ready edge
    assign acc      = psel && penable;
    assign wr       = acc && pwrite && st_r.ack;
    assign rd       = acc && !pwrite && st_r.ack;
    assign rd_load  = acc && !pwrite && !st_r.ack;
    assign wr_lane0 = wr && pstrb[0];
    assign pready   = st_r.ack;
    assign pslverr  = st_r.ack && acc && !hit;
    assign prdata   = st_r.rdata;
    assign irq      = st_r.irq_out;

    // ------------------------------------------------------------------
    // clock source selection and prescaler
    // ------------------------------------------------------------------
    // the filtered level takes the third stage only when the second and third
    // stages agree; the first stage feeds only the second
    assign ext_new = (st_r.ext_sync[1] == st_r.ext_sync[2]) ? st_r.ext_sync[2] : st_r.ext_lvl;
    assign fix_new = (st_r.fix_sync[1] == st_r.fix_sync[2]) ? st_r.fix_sync[2] : st_r.fix_lvl;

    always_comb
    begin
        case (st_r.clk_src)
            modulo_timer_pkg::SRC_BUS:  src_tick = 1'b1;
            modulo_timer_pkg::SRC_FIX:  src_tick = fix_new && !st_r.fix_lvl;
            modulo_timer_pkg::SRC_FALL: src_tick = !ext_new && st_r.ext_lvl;
            modulo_timer_pkg::SRC_RISE: src_tick = ext_new && !st_r.ext_lvl;
            default:            src_tick = 1'b1;
        endcase
    end

    // codes above eight saturate at the 256 divider
    assign ps_eff   = (st_r.prescale > modulo_timer_pkg::PS_MAX) ? modulo_timer_pkg::PS_MAX : st_r.prescale;
    // divide by 2**ps: tick when the low ps bits of the prescaler are all ones
    assign pre_mask = (ps_eff == modulo_timer_pkg::PS_MAX) ? 8'hff : 8'((9'h001 << ps_eff) - 9'h001);
    assign pre_tick = src_tick && ((st_r.pre_cnt & pre_mask) == pre_mask) && !st_r.halt;
    assign wrap     = pre_tick && (st_r.count == st_r.limit) && (st_r.limit != 8'h00
                      || st_r.count == 8'h00 ? 1'b1 : 1'b0) && (st_r.limit != 8'h00 || 1'b0)
                      || pre_tick && (st_r.limit == 8'h00) && (st_r.count == 8'hff);

    // ------------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            modulo_timer_pkg::OFF_STATUS_CONTROL: rd_byte = {st_r.ovf_flag, st_r.ovf_ie, 1'b0, st_r.halt, 4'h0};
            modulo_timer_pkg::OFF_CLOCK_CONFIG:   rd_byte = {2'h0, st_r.clk_src, st_r.prescale};
            modulo_timer_pkg::OFF_CURRENT_COUNT:  rd_byte = st_r.count;
            modulo_timer_pkg::OFF_WRAP_LIMIT:     rd_byte = st_r.limit;
            modulo_timer_pkg::OFF_IRQ_STATUS:     rd_byte = {7'h00, st_r.irq_sticky};
            modulo_timer_pkg::OFF_IRQ_MASK:       rd_byte = {7'h00, st_r.irq_mask};
            default:                      hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.ext_sync = {st_r.ext_sync[1:0], external_timer_clock};
        st_nxt.fix_sync = {st_r.fix_sync[1:0], fixed_frequency_clock};
        st_nxt.ext_lvl  = ext_new;
        st_nxt.fix_lvl  = fix_new;
        st_nxt.ack      = acc && !st_r.ack;
        if (src_tick && !st_r.halt)
        begin
            st_nxt.pre_cnt = st_r.pre_cnt + 8'h01;
        end
        if (pre_tick)
        begin
            st_nxt.count = wrap ? 8'h00 : st_r.count + 8'h01;
        end
        // arm only if the word that software is taking shows the flag set
        if (rd && paddr == modulo_timer_pkg::OFF_STATUS_CONTROL && st_r.rdata[modulo_timer_pkg::BIT_OVF_FLAG])
        begin
            st_nxt.ovf_armed = 1'b1;
        end
        if (wr_lane0 && paddr == modulo_timer_pkg::OFF_STATUS_CONTROL)
        begin
            st_nxt.ovf_ie = pwdata[modulo_timer_pkg::BIT_OVF_IE];
            st_nxt.halt   = pwdata[modulo_timer_pkg::BIT_CNT_HALT];
            if (st_r.ovf_armed && !pwdata[modulo_timer_pkg::BIT_OVF_FLAG])
            begin
                st_nxt.ovf_flag = 1'b0;
            end
            st_nxt.ovf_armed = 1'b0;
            if (pwdata[modulo_timer_pkg::BIT_CNT_CLEAR])
            begin
                st_nxt.count    = modulo_timer_pkg::RST_COUNT;
                st_nxt.pre_cnt  = modulo_timer_pkg::RST_PRE_CNT;
                st_nxt.ovf_flag = 1'b0;
            end
        end
        if (wr_lane0 && paddr == modulo_timer_pkg::OFF_CLOCK_CONFIG)
        begin
            st_nxt.clk_src  = pwdata[modulo_timer_pkg::POS_CLK_SRC +: 2];
            st_nxt.prescale = pwdata[modulo_timer_pkg::POS_PRESCALE +: 4];
        end
        if (wr_lane0 && paddr == modulo_timer_pkg::OFF_WRAP_LIMIT)
        begin
            st_nxt.limit    = pwdata[7:0];
            st_nxt.count    = modulo_timer_pkg::RST_COUNT;
            st_nxt.pre_cnt  = modulo_timer_pkg::RST_PRE_CNT;
            st_nxt.ovf_flag = 1'b0;
        end
        if (wr_lane0 && paddr == modulo_timer_pkg::OFF_IRQ_MASK)
        begin
            st_nxt.irq_mask = pwdata[0];
        end
        if (wr_lane0 && paddr == modulo_timer_pkg::OFF_IRQ_STATUS && pwdata[0])
        begin
            st_nxt.irq_sticky = 1'b0;
        end
        // an overflow beats any clear in the same cycle and restarts the
        // two-step clear so a second overflow is never lost
        if (wrap)
        begin
            st_nxt.ovf_flag   = 1'b1;
            st_nxt.ovf_armed  = 1'b0;
            st_nxt.irq_sticky = 1'b1;
        end
        st_nxt.irq_out = (st_r.ovf_ie && st_r.ovf_flag) || (st_r.irq_sticky && st_r.irq_mask);
        st_nxt.rdata   = rd_load ? {24'h000000, rd_byte} : st_r.rdata;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r          <= '0;
            st_r.halt     <= modulo_timer_pkg::RST_HALT;
            st_r.clk_src  <= modulo_timer_pkg::RST_CLK_SRC;
            st_r.prescale <= modulo_timer_pkg::RST_PRESCALE;
            st_r.count    <= modulo_timer_pkg::RST_COUNT;
            st_r.limit    <= modulo_timer_pkg::RST_LIMIT;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    wrap_sets_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wrap |=> st_r.ovf_flag && st_r.count == 8'h00)
        else $error("overflow did not set flag");

    unarmed_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.ovf_flag && !st_r.ovf_armed && !wrap && !(wr && pwdata[modulo_timer_pkg::BIT_CNT_CLEAR])
        && paddr != modulo_timer_pkg::OFF_WRAP_LIMIT |=> st_r.ovf_flag)
        else $error("flag cleared without prior read");

    limit_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_lane0 && paddr == modulo_timer_pkg::OFF_WRAP_LIMIT && !wrap |=> !st_r.ovf_flag && st_r.count == 8'h00)
        else $error("limit write did not clear");

    irq_level_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.ovf_ie && st_r.ovf_flag |=> irq)
        else $error("irq not raised");

    halt_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.halt && !wr |=> $stable(st_r.count))
        else $error("count moved while halted");

    read_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd && paddr == modulo_timer_pkg::OFF_STATUS_CONTROL |=> prdata[5] == 1'b0 && prdata[3:0] == 4'h0)
        else $error("unused status bits nonzero");

    bus_div1_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !st_r.halt && st_r.clk_src == modulo_timer_pkg::SRC_BUS && st_r.prescale == 4'h0 && !wr
        && st_r.count != st_r.limit && !(st_r.limit == 8'h00 && st_r.count == 8'hff)
        |=> st_r.count == $past(st_r.count) + 8'h01)
        else $error("divide by one not counting");

    count_ro_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr && paddr == modulo_timer_pkg::OFF_CURRENT_COUNT && st_r.halt |=> $stable(st_r.count))
        else $error("count register written");

    // ------------------------------------------------------------------
    // bus handshake assertions
    // ------------------------------------------------------------------
    ready_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        acc && !st_r.ack |-> !pready)
        else $error("ready high in first access cycle");

    ready_done_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        acc && !pready |=> pready)
        else $error("ready not given after one wait state");

    ready_drop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        pready |=> !pready)
        else $error("ready held for two cycles");

    slverr_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        pslverr |-> pready)
        else $error("error flagged outside ready cycle");

    rdata_upper_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        prdata[31:8] == 24'h000000)
        else $error("read data upper bits nonzero");

    // ------------------------------------------------------------------
    // register and flag assertions
    // ------------------------------------------------------------------
    cfg_unused_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_load && paddr == modulo_timer_pkg::OFF_CLOCK_CONFIG |=> prdata[7:6] == 2'h0)
        else $error("unused config bits nonzero");

    strobe_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_lane0 && paddr == modulo_timer_pkg::OFF_STATUS_CONTROL && pwdata[modulo_timer_pkg::BIT_CNT_CLEAR]
        |=> st_r.count == 8'h00 && (!st_r.ovf_flag || $past(wrap)))
        else $error("clear strobe did not reset count");

    armed_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_lane0 && paddr == modulo_timer_pkg::OFF_STATUS_CONTROL && st_r.ovf_armed
        && !pwdata[modulo_timer_pkg::BIT_OVF_FLAG] && !wrap |=> !st_r.ovf_flag)
        else $error("armed clear did not clear flag");

    wrap_rearm_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wrap |=> !st_r.ovf_armed)
        else $error("overflow did not restart clear");

    irq_quiet_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !st_r.ovf_ie && !(st_r.irq_sticky && st_r.irq_mask) |=> !irq)
        else $error("irq raised while disabled");

    // ------------------------------------------------------------------
    // counting assertions
    // ------------------------------------------------------------------
    halt_prescale_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.halt && !wr |=> $stable(st_r.pre_cnt))
        else $error("prescaler moved while halted");

    tick_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        pre_tick |-> src_tick && !st_r.halt)
        else $error("count tick without source or while halted");

    config_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_lane0 && paddr == modulo_timer_pkg::OFF_CLOCK_CONFIG |=> st_r.count == $past(st_r.count)
        || st_r.count == $past(st_r.count) + 8'h01 || st_r.count == 8'h00)
        else $error("config write disturbed count");

    div_sat_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.prescale > modulo_timer_pkg::PS_MAX |-> pre_mask == 8'hff)
        else $error("high prescale code not at 256");

    count_bound_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.limit != 8'h00 |-> st_r.count <= st_r.limit)
        else $error("count above limit");

    mod_wrap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.limit != 8'h00 && pre_tick && st_r.count == st_r.limit |=> st_r.count == 8'h00)
        else $error("count did not wrap at limit");

    free_wrap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.limit == 8'h00 && pre_tick && st_r.count == 8'hff |=> st_r.count == 8'h00 && st_r.ovf_flag)
        else $error("free run did not wrap");

    // ------------------------------------------------------------------
    // clock source assertions
    // ------------------------------------------------------------------
    bus_source_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.clk_src == modulo_timer_pkg::SRC_BUS |-> src_tick)
        else $error("bus source not ticking");

    rise_source_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.clk_src == modulo_timer_pkg::SRC_RISE && src_tick |-> !st_r.ext_lvl && ext_new)
        else $error("rising source ticked without rise");

    fall_source_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.clk_src == modulo_timer_pkg::SRC_FALL && src_tick |-> st_r.ext_lvl && !ext_new)
        else $error("falling source ticked without fall");

    fix_source_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.clk_src == modulo_timer_pkg::SRC_FIX && src_tick |-> !st_r.fix_lvl && fix_new)
        else $error("fixed source ticked without rise");

    ext_filter_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.ext_sync[1] != st_r.ext_sync[2] |=> st_r.ext_lvl == $past(st_r.ext_lvl))
        else $error("pin level taken before stages agree");

    fix_filter_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_r.fix_sync[1] != st_r.fix_sync[2] |=> st_r.fix_lvl == $past(st_r.fix_lvl))
        else $error("fixed clock level taken before stages agree");
endmodule : modulo_timer_timer

// [modulo_timer_pkg.sv]
// package: register map, field positions and reset values of the modulo timer
package modulo_timer_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_STATUS_CONTROL = 12'h000;
    localparam logic [11:0] OFF_CLOCK_CONFIG   = 12'h004;
    localparam logic [11:0] OFF_CURRENT_COUNT  = 12'h008;
    localparam logic [11:0] OFF_WRAP_LIMIT     = 12'h00c;
    localparam logic [11:0] OFF_IRQ_STATUS     = 12'h010;
    localparam logic [11:0] OFF_IRQ_MASK       = 12'h014;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_OVF_FLAG   = 7;
    localparam int BIT_OVF_IE     = 6;
    localparam int BIT_CNT_CLEAR  = 5;
    localparam int BIT_CNT_HALT   = 4;
    localparam int POS_CLK_SRC    = 4;
    localparam int POS_PRESCALE   = 0;
    // ------------------------------------------------------------------
    // reset values and highest prescale code
    // ------------------------------------------------------------------
    localparam logic       RST_HALT     = 1'b1;
    localparam logic [1:0] RST_CLK_SRC  = 2'h0;
    localparam logic [3:0] RST_PRESCALE = 4'h0;
    localparam logic [7:0] RST_COUNT    = 8'h00;
    localparam logic [7:0] RST_LIMIT    = 8'h00;
    localparam logic [7:0] RST_PRE_CNT  = 8'h00;
    localparam logic [3:0] PS_MAX       = 4'h8;
    // clock source codes
    localparam logic [1:0] SRC_BUS  = 2'h0;
    localparam logic [1:0] SRC_FIX  = 2'h1;
    localparam logic [1:0] SRC_FALL = 2'h2;
    localparam logic [1:0] SRC_RISE = 2'h3;
endpackage : modulo_timer_pkg

// [testbench.sv]
// testbench: register-level self-checking bench for the modulo timer
`timescale 1ns/100ps
module testbench;
    // ------------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------------
    localparam logic [11:0] A_SC  = modulo_timer_pkg::OFF_STATUS_CONTROL;
    localparam logic [11:0] A_CF  = modulo_timer_pkg::OFF_CLOCK_CONFIG;
    localparam logic [11:0] A_CN  = modulo_timer_pkg::OFF_CURRENT_COUNT;
    localparam logic [11:0] A_LM  = modulo_timer_pkg::OFF_WRAP_LIMIT;
    logic        clk_sys = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fix_clk = 1'b0;
    logic        ext_clk = 1'b0;
    logic        irq;
    logic        err;
    logic [31:0] rd;
    int          n_fail  = 0;
    int          checked = 0;
    int          cyc     = 0;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    modulo_timer_timer modulo_timer_timer_inst (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fixed_frequency_clock(fix_clk),
        .external_timer_clock(ext_clk), .irq(irq));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // entered right after a rising edge; write and read data meet at the ready edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic ws(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : ws
    task automatic rs(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rs
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk("irq raised", 32'h1, {31'h0, irq});
    endtask : wait_irq
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] held;
        rs(A_SC);  chk("status reset", 32'h10, rd);
        rs(A_CF);  chk("config reset", 32'h00, rd);
        rs(A_LM);  chk("limit reset", 32'h00, rd);
        rs(12'h0f0); chk("unmapped error", 32'h1, {31'h0, err});
        ws(A_LM, 8'h03);
        ws(A_SC, 8'h00);
        while (rd[7] !== 1'b1 && cyc < 400) rs(A_SC); // flag poll also arms the clear
        chk("flag set", 32'h1, {31'h0, rd[7]});
        ws(A_SC, 8'h10); // halt first so no overflow restarts the clear
        rs(A_CN);  chk("count within limit", 32'h1, {31'h0, rd[7:0] <= 8'h03});
        rs(A_SC);  chk("flag held", 32'h90, rd);
        ws(A_SC, 8'h10);
        rs(A_SC);  chk("flag cleared", 32'h10, rd);
        rs(A_CN);  held = rd[7:0];
        repeat (20) @(posedge clk_sys);
        ws(A_CN, 8'haa);
        rs(A_CN);  chk("count held", {24'h0, held}, rd);
        $display("test regs done");
    endtask : t_regs
    task automatic t_irq();
        ws(A_SC, 8'h40);
        wait_irq();
        ws(A_SC, 8'h50); // no read before: flag must survive
        rs(A_SC);  chk("flag kept", 32'hd0, rd);
        ws(A_SC, 8'h50);
        rs(A_SC);  chk("flag cleared", 32'h50, rd);
        chk("irq low", 32'h0, {31'h0, irq});
        rs(modulo_timer_pkg::OFF_IRQ_STATUS); chk("sticky set", 32'h1, rd);
        ws(modulo_timer_pkg::OFF_IRQ_MASK, 8'h01);
        rs(A_SC);  chk("masked irq", 32'h1, {31'h0, irq});
        ws(modulo_timer_pkg::OFF_IRQ_STATUS, 8'h01);
        ws(modulo_timer_pkg::OFF_IRQ_MASK, 8'h00);
        rs(modulo_timer_pkg::OFF_IRQ_STATUS); chk("sticky clear", 32'h0, {31'h0, irq | rd[0]});
        ws(A_SC, 8'h40);
        wait_irq();
        ws(A_SC, 8'h50); // halt so no overflow meets the strobe
        ws(A_SC, 8'h70);
        rs(A_SC);  chk("strobe clears", 32'h50, rd);
        rs(A_CN);  chk("count zeroed", 32'h0, rd);
        ws(A_SC, 8'h40);
        wait_irq();
        ws(A_SC, 8'h50);
        ws(A_LM, 8'h03);
        rs(A_SC);  chk("limit write clears", 32'h50, rd);
        rs(A_CN);  chk("limit write zeroes", 32'h0, rd);
        ws(A_SC, 8'h10);
        $display("test irq done");
    endtask : t_irq
    task automatic t_prescale();
        logic [3:0] code;
        logic [7:0] c0;
        logic [7:0] dl;
        int         div;
        int         t0;
        int         ex;
        ws(A_LM, 8'h00);
        ws(A_SC, 8'h00);
        for (int k = 0; k < 10; k++)
        begin
            code = (k < 9) ? 4'(k) : 4'hf;
            div = 1 << ((k < 9) ? k : 8);
            ws(A_CF, {4'hc, code});
            rs(A_CF); chk("config bits", {28'h0, code}, rd);
            rs(A_CN); c0 = rd[7:0]; t0 = cyc;
            repeat (8 * div) @(posedge clk_sys);
            rs(A_CN); dl = rd[7:0] - c0; ex = (cyc - t0) / div;
            chk("prescale rate", 32'h1, {31'h0, dl >= ex - 1 && dl <= ex + 1});
        end
        $display("test prescale done");
    endtask : t_prescale
    task automatic t_source();
        logic [7:0] prev;
        rs(A_CN); prev = rd[7:0];
        for (int s = 1; s < 4; s++)
        begin
            ws(A_CF, {2'b00, 2'(s), 4'h0});
            if (s > 1) rs(A_CN);
            if (s > 1) chk("count kept", {24'h0, prev}, rd);
            ws(A_SC, 8'h20);
            for (int i = 0; i < 6; i++)
            begin
                if (s == 1) fix_clk <= 1'b1; else ext_clk <= 1'b1;
                repeat (4) @(posedge clk_sys);
                if (i < 5 && s == 1) fix_clk <= 1'b0;
                if (i < 5 && s > 1) ext_clk <= 1'b0;
                repeat (4) @(posedge clk_sys);
            end
            repeat (8) @(posedge clk_sys);
            rs(A_CN); chk("source edges", (s == 2) ? 32'h5 : 32'h6, rd);
            fix_clk <= 1'b0;
            ext_clk <= 1'b0;
            repeat (8) @(posedge clk_sys);
            rs(A_CN); prev = rd[7:0];
        end
        $display("test source done");
    endtask : t_source
    // ------------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_irq();
        t_prescale();
        t_source();
        test_done();
    end
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        n_fail++;
        test_done();
    end
endmodule : testbench
